// ==== src/wwdt_core_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface wwdt_core_if;
  logic presc_sel;
  logic run;
  logic tick;
  logic [wwdt_pkg::EVT_W-1:0] evt;
  logic [wwdt_pkg::EVT_W-1:0] irq_clr;
  logic [wwdt_pkg::EVT_W-1:0] irq_en;
  logic [wwdt_pkg::EVT_W-1:0] irq_status;
  logic irq;

  modport core (output presc_sel, output run, input tick, output evt, output irq_clr,
    output irq_en, input irq_status, input irq);
  modport presc (input presc_sel, input run, output tick);
  modport intc (input evt, input irq_clr, input irq_en, output irq_status, output irq);
endinterface
`default_nettype wire

// ==== src/wwdt_intc.sv ====
`timescale 1ns/10ps
`default_nettype none
module wwdt_intc (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core side
  wwdt_core_if.intc cif
);
  import wwdt_pkg::*;

  logic [EVT_W-1:0] status_ff;
  logic [EVT_W-1:0] nxt_status;

  // ----------------------------------------------------------------
  // sticky status, a new event beats a clear in the same cycle
  // ----------------------------------------------------------------
  always_comb begin
    nxt_status = (status_ff & ~cif.irq_clr) | cif.evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= EVT_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign cif.irq_status = status_ff;
  assign cif.irq = |(status_ff & cif.irq_en);

  a_evt_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.evt != EVT_RST) |=> ((status_ff & $past(cif.evt)) == $past(cif.evt)))
    else $error("event lost from status");
endmodule
`default_nettype wire

// ==== src/wwdt_pkg.sv ====
package wwdt_pkg;
  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RELOAD = 8'h04;
  localparam logic [7:0] OFS_WINB = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_INSEL = 0;
  localparam int CTRL_RS = 1;
  localparam int CTRL_EN = 2;
  localparam int CTRL_PR = 4;
  localparam int CTRL_WINEN = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] WINB_RST = 8'h00;
  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int EVT_W = 3;
  localparam int EVT_OVF = 0;
  localparam int EVT_INVALID = 1;
  localparam int EVT_SYSRST = 2;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [5:0] PREWARN_COUNTS = 6'h30;
  localparam logic [5:0] PREWARN_LAST = PREWARN_COUNTS - 6'h01;
  localparam logic [6:0] DIV_FAST = 7'h02;
  localparam logic [6:0] DIV_SLOW = 7'h00; // 128 wraps to zero in 7 bits
  localparam logic [6:0] DIV_RST = 7'h00;

  typedef enum logic [1:0] {
    WWDT_RUN = 2'b00,
    WWDT_PREWARN = 2'b01,
    WWDT_RESET = 2'b10
  } wwdt_state_t;
endpackage

// ==== src/wwdt_presc.sv ====
`timescale 1ns/10ps
`default_nettype none
module wwdt_presc (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core side
  wwdt_core_if.presc cif
);
  import wwdt_pkg::*;

  logic [6:0] div_ff;
  logic [6:0] nxt_div;
  logic [6:0] gap_ff;

  // ----------------------------------------------------------------
  // divide by 2 or by 128
  // ----------------------------------------------------------------
  always_comb begin
    if (!cif.run) begin
      nxt_div = DIV_RST;
    end else begin
      nxt_div = div_ff + 7'h01;
      if (!cif.presc_sel && div_ff == (DIV_FAST - 7'h01)) begin
        nxt_div = DIV_RST;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= DIV_RST;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // one tick per wrap, so the counter period carries the 2 or 128 factor
  assign cif.tick = cif.run && (nxt_div == DIV_RST);

  // helper: cycles since the previous tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff <= DIV_RST;
    end else if (cif.tick || !cif.run) begin
      gap_ff <= DIV_RST;
    end else begin
      gap_ff <= gap_ff + 7'h01;
    end
  end

  a_presc_fast: assert property (@(posedge pclk) disable iff (!presetn)
    cif.tick && !cif.presc_sel |=> !cif.tick ##1
    (cif.tick || cif.presc_sel || !cif.run || !$past(cif.run)))
    else $error("fast prescale tick spacing wrong");
  a_presc_slow: assert property (@(posedge pclk) disable iff (!presetn)
    cif.tick && cif.presc_sel && $stable(cif.presc_sel) && $past(cif.run) && gap_ff != 7'h00
    |-> gap_ff == 7'h7f)
    else $error("slow prescale tick spacing wrong");
endmodule
`default_nettype wire

// ==== src/wwdt_top.sv ====
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module wwdt_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wwdt_pkg::ADDR_W-1:0] paddr,
  input wire logic [wwdt_pkg::DATA_W-1:0] pwdata,
  output logic [wwdt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // watchdog outputs
  output logic watchdog_nmi_request,
  output logic watchdog_system_reset,
  output logic irq
);
  import wwdt_pkg::*;

  wwdt_core_if cif ();

  // ----------------------------------------------------------------
  // register and state storage
  // ----------------------------------------------------------------
  logic input_prescale_select_ff;
  logic nxt_input_prescale_select;
  logic watchdog_enable_bit_ff;
  logic nxt_watchdog_enable_bit;
  logic window_check_enable_ff;
  logic nxt_window_check_enable;
  logic refresh_strobe_ff;
  logic nxt_refresh_strobe;
  logic [7:0] reload_high_byte_ff;
  logic [7:0] nxt_reload_high_byte;
  logic [7:0] window_boundary_byte_ff;
  logic [7:0] nxt_window_boundary_byte;
  logic [EVT_W-1:0] irq_en_ff;
  logic [EVT_W-1:0] nxt_irq_en;
  logic [DATA_W-1:0] prdata_ff;
  logic [DATA_W-1:0] nxt_prdata;
  wwdt_state_t state_ff;
  wwdt_state_t nxt_state;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [5:0] pw_cnt_ff;
  logic [5:0] nxt_pw_cnt;
  logic nmi_ff;
  logic nxt_nmi;
  logic sysrst_ff;
  logic nxt_sysrst;
  logic [EVT_W-1:0] evt;

  logic setup;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic in_window;
  logic prewarning;
  logic [15:0] reload_value;
  logic [15:0] boundary_value;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = setup && !pwrite;
  assign mapped = is_reg(paddr, OFS_CTRL) || is_reg(paddr, OFS_RELOAD) ||
    is_reg(paddr, OFS_WINB) || is_reg(paddr, OFS_COUNT) || is_reg(paddr, OFS_IRQ_STATUS) ||
    is_reg(paddr, OFS_IRQ_CLEAR) || is_reg(paddr, OFS_IRQ_ENABLE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_ff;

  assign prewarning = (state_ff == WWDT_PREWARN);
  assign reload_value = {reload_high_byte_ff, 8'h00};
  assign boundary_value = {window_boundary_byte_ff, 8'h00};
  assign in_window = window_check_enable_ff && (count_ff < boundary_value);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    nxt_input_prescale_select = input_prescale_select_ff;
    nxt_watchdog_enable_bit = watchdog_enable_bit_ff;
    nxt_window_check_enable = window_check_enable_ff;
    nxt_reload_high_byte = reload_high_byte_ff;
    nxt_window_boundary_byte = window_boundary_byte_ff;
    nxt_irq_en = irq_en_ff;
    // strobe is consumed by the counter logic one cycle after it is set
    nxt_refresh_strobe = 1'b0;
    cif.irq_clr = EVT_RST;
    if (wr_en && is_reg(paddr, OFS_CTRL)) begin
      nxt_input_prescale_select = pwdata[CTRL_INSEL];
      nxt_watchdog_enable_bit = pwdata[CTRL_EN];
      nxt_window_check_enable = pwdata[CTRL_WINEN];
      nxt_refresh_strobe = pwdata[CTRL_RS];
    end
    if (wr_en && is_reg(paddr, OFS_RELOAD)) begin
      nxt_reload_high_byte = pwdata[7:0];
    end
    if (wr_en && is_reg(paddr, OFS_WINB)) begin
      nxt_window_boundary_byte = pwdata[7:0];
    end
    if (wr_en && is_reg(paddr, OFS_IRQ_ENABLE)) begin
      nxt_irq_en = pwdata[EVT_W-1:0];
    end
    if (wr_en && is_reg(paddr, OFS_IRQ_CLEAR)) begin
      cif.irq_clr = pwdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_prescale_select_ff <= CTRL_RST[CTRL_INSEL];
      watchdog_enable_bit_ff <= CTRL_RST[CTRL_EN];
      window_check_enable_ff <= CTRL_RST[CTRL_WINEN];
      refresh_strobe_ff <= CTRL_RST[CTRL_RS];
      reload_high_byte_ff <= RELOAD_RST;
      window_boundary_byte_ff <= WINB_RST;
      irq_en_ff <= EVT_RST;
    end else begin
      input_prescale_select_ff <= nxt_input_prescale_select;
      watchdog_enable_bit_ff <= nxt_watchdog_enable_bit;
      window_check_enable_ff <= nxt_window_check_enable;
      refresh_strobe_ff <= nxt_refresh_strobe;
      reload_high_byte_ff <= nxt_reload_high_byte;
      window_boundary_byte_ff <= nxt_window_boundary_byte;
      irq_en_ff <= nxt_irq_en;
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------------------------------
  always_comb begin
    nxt_prdata = prdata_ff;
    if (rd_setup) begin
      nxt_prdata = '0;
      case (paddr)
        OFS_CTRL: begin
          nxt_prdata[CTRL_INSEL] = input_prescale_select_ff;
          nxt_prdata[CTRL_RS] = refresh_strobe_ff;
          nxt_prdata[CTRL_EN] = watchdog_enable_bit_ff;
          nxt_prdata[CTRL_PR] = prewarning;
          nxt_prdata[CTRL_WINEN] = window_check_enable_ff;
        end
        OFS_RELOAD: nxt_prdata[7:0] = reload_high_byte_ff;
        OFS_WINB: nxt_prdata[7:0] = window_boundary_byte_ff;
        OFS_COUNT: nxt_prdata[15:0] = count_ff;
        OFS_IRQ_STATUS: nxt_prdata[EVT_W-1:0] = cif.irq_status;
        OFS_IRQ_ENABLE: nxt_prdata[EVT_W-1:0] = irq_en_ff;
        default: nxt_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter and sequence
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_pw_cnt = pw_cnt_ff;
    nxt_nmi = nmi_ff;
    nxt_sysrst = sysrst_ff;
    evt = EVT_RST;
    case (state_ff)
      WWDT_RUN: begin
        if (refresh_strobe_ff) begin
          if (in_window) begin
            nxt_state = WWDT_PREWARN;
            nxt_pw_cnt = 6'h00;
            evt[EVT_INVALID] = 1'b1;
          end else begin
            nxt_count = reload_value;
          end
        end else if (cif.tick) begin
          if (count_ff == COUNT_MAX) begin
            nxt_state = WWDT_PREWARN;
            nxt_nmi = 1'b1;
            nxt_pw_cnt = 6'h00;
            evt[EVT_OVF] = 1'b1;
          end
          nxt_count = count_ff + 16'h0001;
        end
      end
      WWDT_PREWARN: begin
        if (cif.tick) begin
          nxt_count = count_ff + 16'h0001;
          nxt_pw_cnt = pw_cnt_ff + 6'h01;
          if (pw_cnt_ff == PREWARN_LAST) begin
            nxt_state = WWDT_RESET;
            nxt_sysrst = 1'b1;
            evt[EVT_SYSRST] = 1'b1;
          end
        end
      end
      WWDT_RESET: begin
        nxt_sysrst = 1'b1;
      end
      default: begin
        nxt_state = WWDT_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= WWDT_RUN;
      count_ff <= COUNT_RST;
      pw_cnt_ff <= 6'h00;
      nmi_ff <= 1'b0;
      sysrst_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      pw_cnt_ff <= nxt_pw_cnt;
      nmi_ff <= nxt_nmi;
      sysrst_ff <= nxt_sysrst;
    end
  end

  assign watchdog_nmi_request = nmi_ff;
  assign watchdog_system_reset = sysrst_ff;

  // ----------------------------------------------------------------
  // prescaler and interrupt controller
  // ----------------------------------------------------------------
  // prewarning keeps running even if software drops the enable
  assign cif.run = watchdog_enable_bit_ff || prewarning;
  assign cif.presc_sel = input_prescale_select_ff;
  assign cif.evt = evt;
  assign cif.irq_en = irq_en_ff;
  assign irq = cif.irq;

  wwdt_presc u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif.presc)
  );

  wwdt_intc u_intc (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif.intc)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ovf_to_nmi: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == WWDT_RUN && !refresh_strobe_ff && cif.tick && count_ff == COUNT_MAX
    |=> watchdog_nmi_request && state_ff == WWDT_PREWARN && count_ff == COUNT_RST)
    else $error("overflow did not raise nmi and prewarning");
  a_prewarn_end: assert property (@(posedge pclk) disable iff (!presetn)
    prewarning && cif.tick && pw_cnt_ff == 6'h2f |=> watchdog_system_reset)
    else $error("reset not asserted after prewarning");
  a_prewarn_early: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(watchdog_system_reset) |-> $past(pw_cnt_ff) == 6'h2f && $past(prewarning))
    else $error("reset asserted before prewarning end");
  a_invalid_refresh: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == WWDT_RUN && refresh_strobe_ff && window_check_enable_ff &&
    count_ff < {window_boundary_byte_ff, 8'h00}
    |=> prewarning && !watchdog_nmi_request ##1 !watchdog_nmi_request)
    else $error("invalid refresh handled wrongly");
  a_valid_reload: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == WWDT_RUN && refresh_strobe_ff && !window_check_enable_ff
    |=> count_ff == {$past(reload_high_byte_ff), 8'h00} && !prewarning)
    else $error("service did not reload counter");
  a_window_open: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == WWDT_RUN && refresh_strobe_ff && count_ff >= {window_boundary_byte_ff, 8'h00}
    |=> state_ff == WWDT_RUN)
    else $error("refresh outside window caused prewarning");
  a_reload_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFS_RELOAD |=> reload_high_byte_ff == $past(pwdata[7:0]))
    else $error("reload register not written");
  a_disabled_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !watchdog_enable_bit_ff && state_ff == WWDT_RUN && !refresh_strobe_ff
    |=> count_ff == $past(count_ff))
    else $error("counter moved while disabled");
  a_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && paddr == OFS_CTRL |=> prdata[CTRL_PR] == $past(prewarning))
    else $error("prewarning flag reads wrong");
endmodule
`default_nettype wire

// ==== test/wwdt_top_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module wwdt_top_bench;
  import wwdt_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic watchdog_nmi_request;
  logic watchdog_system_reset;
  logic irq;
  int failures = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h3bbd;
  logic [31:0] rd;
  logic err;

  always #10 pclk = ~pclk;

  wwdt_top wwdt_top_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .watchdog_nmi_request(watchdog_nmi_request),
    .watchdog_system_reset(watchdog_system_reset),
    .irq(irq)
  );
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // pclk cycles from service to overflow
  function automatic int period(input logic sel, input logic [7:0] rel);
    return (1 << (1 + 6 * int'(sel))) * (65536 - int'(rel) * 256);
  endfunction

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_near(input string name, input int exp, input int got, input int tol);
    checks_done++;
    if (got < exp - tol || got > exp + tol) begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready", 32'h1, 32'h0);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic wait_for(input logic which, input int bound, output int n);
    n = 0;
    while ((which ? watchdog_system_reset : watchdog_nmi_request) !== 1'b1) begin
      @(negedge pclk);
      n++;
      if (n > bound) begin
        chk("wait bound", 32'h1, 32'h0);
        end_sim();
      end
    end
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // refresh with the counter stopped so the reload value lands exactly
  task automatic service(input logic [7:0] rel);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_RELOAD, {24'h0, rel});
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_RS);
    rchk("count reload", OFS_COUNT, {16'h0, rel, 8'h00});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic run_ovf(input logic sel, input logic [7:0] rel);
    int n;
    int m;
    logic [31:0] ctl;
    ctl = (32'h1 << CTRL_EN) | {31'h0, sel};
    service(rel);
    apb(1'b1, OFS_CTRL, ctl);
    wait_for(1'b0, period(sel, rel) + 300, n);
    chk_near("overflow cycles", period(sel, rel), n, 4);
    rchk("prewarn flag", OFS_CTRL, ctl | (32'h1 << CTRL_PR));
    wait_for(1'b1, 7000, m);
    chk_near("prewarn cycles", 48 * (sel ? 128 : 2), m + 3, 4);
    chk("nmi held", 32'h1, {31'h0, watchdog_nmi_request});
    rchk("status", OFS_IRQ_STATUS, 32'h5);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h4);
    @(negedge pclk);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, OFS_IRQ_ENABLE, 32'h2);
    @(negedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_IRQ_ENABLE, 32'h7);
    apb(1'b1, OFS_IRQ_CLEAR, 32'h7);
    @(negedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rchk("status cleared", OFS_IRQ_STATUS, 32'h0);
    do_reset();
  endtask

  // refresh either at once after service or once the count passed the boundary
  task automatic win(input logic en, input logic [7:0] rel, input logic [7:0] winb,
    input logic late);
    int n;
    logic bad;
    logic [31:0] ctl;
    ctl = (32'h1 << CTRL_EN) | ({31'h0, en} << CTRL_WINEN);
    bad = en && !late;
    apb(1'b1, OFS_WINB, {24'h0, winb});
    service(rel);
    apb(1'b1, OFS_CTRL, ctl);
    n = 0;
    rd = 32'h0;
    while (late && rd[15:0] < {winb, 8'h00}) begin
      apb(1'b0, OFS_COUNT, 32'h0);
      n++;
      if (n > 2000) begin
        chk("count poll", 32'h1, 32'h0);
        end_sim();
      end
    end
    apb(1'b1, OFS_CTRL, ctl | (32'h1 << CTRL_RS));
    rchk("window flag", OFS_CTRL, ctl | ({31'h0, bad} << CTRL_PR));
    if (bad) begin
      wait_for(1'b1, 150, n);
      chk_near("invalid prewarn", 96, n + 6, 6);
      chk("no nmi", 32'h0, {31'h0, watchdog_nmi_request});
      rchk("status invalid", OFS_IRQ_STATUS, 32'h6);
      do_reset();
    end else begin
      apb(1'b0, OFS_COUNT, 32'h0);
      chk("count high", {24'h0, rel}, {24'h0, rd[15:8]});
      rchk("status none", OFS_IRQ_STATUS, 32'h0);
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [7:0] r;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 8'h18; a += 4) begin
      rchk("reset value", a[7:0], 32'h0);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, (i == 0) ? 8'h1c : 8'h80, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
    end
    apb(1'b1, OFS_COUNT, 32'hffff);
    rchk("count read only", OFS_COUNT, 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      apb(1'b1, OFS_RELOAD, v);
      rchk("reload rw", OFS_RELOAD, {24'h0, v[7:0]});
      apb(1'b1, OFS_WINB, ~v);
      rchk("winb rw", OFS_WINB, {24'h0, ~v[7:0]});
      apb(1'b1, OFS_CTRL, v & 32'hfffffffb & ~(32'h1 << CTRL_RS));
      rchk("ctrl rw", OFS_CTRL, v & 32'h21);
      apb(1'b1, OFS_IRQ_ENABLE, v);
      rchk("irq enable rw", OFS_IRQ_ENABLE, v & 32'h7);
    end
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0);
    v = rnd();
    run_ovf(1'b0, 8'he0 | (v[7:0] & 8'h1f));
    run_ovf(1'b1, 8'hff);
    win(1'b1, 8'h10, 8'h80, 1'b0);
    win(1'b0, 8'h10, 8'h80, 1'b0);
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      r = 8'h10 | (v[7:0] & 8'h7f);
      win(1'b1, r, r + 8'h01, 1'b0);
      win(1'b1, r, r + 8'h01, 1'b1);
    end
    end_sim();
  end
endmodule
`default_nettype wire
